// ===== hdl/gia_pkg.sv
// Constants and state layout of the global interrupt aggregator.
// Assumes a 32-bit register port where every register takes one aligned word.
package gia_pkg;

  localparam int GIA_ADDR_W    = 17;
  localparam int GIA_DATA_W    = 32;
  localparam int GIA_NUM_PORTS = 8;

  // Register byte addresses
  localparam logic [GIA_ADDR_W-1:0] GIA_STATUS_OFS = 17'h1AC00;
  localparam logic [GIA_ADDR_W-1:0] GIA_ENABLE_OFS = 17'h1AC04;
  localparam logic [GIA_ADDR_W-1:0] GIA_EVENT_OFS  = 17'h1AC20;
  localparam logic [GIA_ADDR_W-1:0] GIA_EVMASK_OFS = 17'h1AC24;

  // Field positions, shared by status, enable, event and event mask
  localparam int GIA_BIT_RESET_SYM  = 4;
  localparam int GIA_BIT_MCAST_EVT  = 5;
  localparam int GIA_BIT_I2C        = 6;
  localparam int GIA_BIT_FABRIC_ERR = 7;
  localparam int GIA_BIT_MULTICAST_LATENCY_IRQ     = 14;
  localparam int GIA_BIT_PORT_LO    = 24;

  // Bits that exist; all others read as zero
  localparam logic [GIA_DATA_W-1:0] GIA_VALID_MASK = 32'hFF0040F0;

  // Values after reset
  localparam logic [GIA_DATA_W-1:0] GIA_ENABLE_RST = 32'h00000000;
  localparam logic [GIA_DATA_W-1:0] GIA_EVMASK_RST = 32'h00000000;
  localparam logic [GIA_DATA_W-1:0] GIA_EVENT_RST  = 32'h00000000;
  localparam logic [GIA_DATA_W-1:0] GIA_PREV_RST   = 32'h00000000;
  localparam logic [GIA_DATA_W-1:0] GIA_RDATA_RST  = 32'h00000000;
  localparam logic                  GIA_PIN_RST    = 1'b1;
  localparam logic                  GIA_EVIRQ_RST  = 1'b0;

  typedef struct packed {
    logic [GIA_DATA_W-1:0] enable;
    logic [GIA_DATA_W-1:0] ev_mask;
    logic [GIA_DATA_W-1:0] ev_sticky;
    logic [GIA_DATA_W-1:0] status_prev;
    logic [GIA_DATA_W-1:0] rdata;
    logic                  int_n;
    logic                  event_irq;
  } gia_state_t;

endpackage : gia_pkg

// ===== hdl/gia_global_irq.sv
// Global interrupt aggregator: live status word, enable gating onto the
// active-low interrupt pin, and a sticky event register with its own mask.
// Assumes all request inputs come from logic on i_core_clk (no synchronisers)
// and that source flags are cleared inside their own blocks.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RL1: Each source's requests are ORed and shown live in its status bit.
// RL2: Status bit 4 is the OR of all ports' reset-symbol requests.
// RL3: Status bit 5 is the OR of all ports' multicast-event requests.
// RL4: Status bit 6 shows the I2C request; enable bit 6 gates it.
// RL5: Status bit 7 shows any fabric transaction error; enable bit 7 gates it.
// RL6: Status bit 14 shows any broadcast buffer multicast latency expiry.
// RL7: Status bits 24..31 show ports 7..0; same-position enable bits gate each.
// RL8: Status bits 0..3 and other reserved bits read zero; status is read-only.
// RL9: The pin asserts only for requests whose enable bit is set.
// RL10: Enable bit 4 is read-write, resets to 0, gates reset-symbol interrupt.
// RL11: Enable bit 5 is read-write, resets to 0, gates multicast-event interrupt.
// RL12: Enable bit 14 read-write, resets 0; reserved enable bits read zero.
// RL13: Clearing a port's error flag at its source removes its pin contribution.
// RL14: Any per-port multicast latency flag raises the global latency bit.
// RL15: Pin is low while status AND enable is nonzero, high otherwise.
// RL16: Writes to the status register change no status bit and not the pin.
module gia_global_irq #(
  parameter int PORT_REQS = 2,
  parameter int I2C_REQS  = 1
) (
  input  wire logic                                  i_core_clk,
  input  wire logic                                  i_arst_n,
  input  wire logic [gia_pkg::GIA_ADDR_W-1:0]        i_addr,
  input  wire logic [gia_pkg::GIA_DATA_W-1:0]        i_wdata,
  input  wire logic                                  i_wr,
  input  wire logic                                  i_rd,
  output logic      [gia_pkg::GIA_DATA_W-1:0]        o_rdata,
  input  wire logic [gia_pkg::GIA_NUM_PORTS*PORT_REQS-1:0] i_port_req,
  input  wire logic [gia_pkg::GIA_NUM_PORTS-1:0]     i_reset_symbol_req,
  input  wire logic [gia_pkg::GIA_NUM_PORTS-1:0]     i_multicast_event_req,
  input  wire logic [I2C_REQS-1:0]                   i_i2c_req,
  input  wire logic [gia_pkg::GIA_NUM_PORTS-1:0]     i_fabric_err,
  input  wire logic [gia_pkg::GIA_NUM_PORTS-1:0]     i_mc_latency_err,
  output logic                                       o_int_n,
  output logic                                       o_event_irq
);
  import gia_pkg::*;

  if (PORT_REQS < 1) begin : g_bad_port_reqs
    $error("PORT_REQS must be at least 1");
  end
  if (I2C_REQS < 1) begin : g_bad_i2c_reqs
    $error("I2C_REQS must be at least 1");
  end

  gia_state_t            st_r;
  gia_state_t            st_nxt;
  logic [GIA_DATA_W-1:0] status_w;
  logic [GIA_DATA_W-1:0] rise_w;
  logic                  hit_status;
  logic                  hit_enable;
  logic                  hit_event;
  logic                  hit_evmask;

  // Live status word; bit index n is the documented bit n
  always_comb begin
    status_w                     = '0;
    status_w[GIA_BIT_RESET_SYM]  = |i_reset_symbol_req;    // RL2
    status_w[GIA_BIT_MCAST_EVT]  = |i_multicast_event_req; // RL3
    status_w[GIA_BIT_I2C]        = |i_i2c_req;             // RL4
    status_w[GIA_BIT_FABRIC_ERR] = |i_fabric_err;          // RL5
    status_w[GIA_BIT_MULTICAST_LATENCY_IRQ]     = |i_mc_latency_err;      // RL6 RL14
    for (int p = 0; p < GIA_NUM_PORTS; p++) begin
      // Port 0 sits in the top bit
      status_w[GIA_BIT_PORT_LO + GIA_NUM_PORTS - 1 - p] = |i_port_req[p*PORT_REQS +: PORT_REQS]; // RL7
    end
  end

  assign hit_status = (i_addr == GIA_STATUS_OFS);
  assign hit_enable = (i_addr == GIA_ENABLE_OFS);
  assign hit_event  = (i_addr == GIA_EVENT_OFS);
  assign hit_evmask = (i_addr == GIA_EVMASK_OFS);
  assign rise_w     = status_w & ~st_r.status_prev;

  always_comb begin
    st_nxt             = st_r;
    st_nxt.status_prev = status_w;
    // A status write falls through: no storage behind that address
    if (i_wr && hit_enable) begin
      st_nxt.enable = i_wdata & GIA_VALID_MASK; // RL10 RL11 RL12
    end
    if (i_wr && hit_evmask) begin
      st_nxt.ev_mask = i_wdata & GIA_VALID_MASK;
    end
    st_nxt.rdata = '0;
    if (i_rd) begin
      case (1'b1)
        hit_status: st_nxt.rdata = status_w & GIA_VALID_MASK; // RL1 RL8
        hit_enable: st_nxt.rdata = st_r.enable;
        hit_event:  st_nxt.rdata = st_r.ev_sticky;
        hit_evmask: st_nxt.rdata = st_r.ev_mask;
        default:    st_nxt.rdata = '0;
      endcase
    end
    // Read clears, but a rising edge in the same cycle survives
    st_nxt.ev_sticky = ((i_rd && hit_event) ? '0 : st_r.ev_sticky) | rise_w;
    // Pin follows the live status one cycle late so it comes from a flop
    st_nxt.int_n     = ~|(status_w & st_r.enable); // RL9 RL13 RL15 RL16
    st_nxt.event_irq = |(st_nxt.ev_sticky & st_nxt.ev_mask);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r.enable      <= GIA_ENABLE_RST;
      st_r.ev_mask     <= GIA_EVMASK_RST;
      st_r.ev_sticky   <= GIA_EVENT_RST;
      st_r.status_prev <= GIA_PREV_RST;
      st_r.rdata       <= GIA_RDATA_RST;
      st_r.int_n       <= GIA_PIN_RST;
      st_r.event_irq   <= GIA_EVIRQ_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata     = st_r.rdata;
  assign o_int_n     = st_r.int_n;
  assign o_event_irq = st_r.event_irq;

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic p0_or_w;
  logic p7_or_w;
  assign p0_or_w = |i_port_req[0 +: PORT_REQS];
  assign p7_or_w = |i_port_req[(GIA_NUM_PORTS-1)*PORT_REQS +: PORT_REQS];

  property pin_follows_p;
    (|(status_w & st_r.enable)) |=> !o_int_n;
  endproperty

  pin_assert_a: assert property (pin_follows_p) // RL15
    else $error("interrupt pin not driven low for enabled request");

  pin_release_a: assert property ( // RL9
    !(|(status_w & st_r.enable)) |=> o_int_n)
    else $error("interrupt pin low without an enabled request");

  status_ro_a: assert property ( // RL16
    (i_wr && hit_status) |=> (st_r.enable == $past(st_r.enable)) && (st_r.ev_mask == $past(st_r.ev_mask)))
    else $error("status write altered a control register");

  enable_write_a: assert property ( // RL10
    (i_wr && hit_enable) |=> st_r.enable == ($past(i_wdata) & GIA_VALID_MASK))
    else $error("enable register did not take written value");

  enable_read_a: assert property ( // RL12
    (i_rd && hit_enable) |=> (o_rdata == $past(st_r.enable)) && ((o_rdata & ~GIA_VALID_MASK) == '0))
    else $error("enable readback wrong or reserved bit set");

  status_read_a: assert property ( // RL8
    (i_rd && hit_status) |=> (o_rdata == $past(status_w)) && (o_rdata[3:0] == 4'h0))
    else $error("status readback wrong or reserved bit set");

  source_bits_a: assert property ( // RL1
    (status_w[GIA_BIT_RESET_SYM] == |i_reset_symbol_req)
    && (status_w[GIA_BIT_MCAST_EVT] == |i_multicast_event_req)
    && (status_w[GIA_BIT_I2C] == |i_i2c_req))
    else $error("source status bit differs from OR of its requests");

  fabric_bit_a: assert property ( // RL13
    (i_fabric_err == '0) && !(|(status_w & ~(32'h1 << GIA_BIT_FABRIC_ERR) & st_r.enable)) |=> o_int_n)
    else $error("cleared fabric errors still drive the pin");

  latency_bit_a: assert property ( // RL14
    $rose(|i_mc_latency_err) |-> status_w[GIA_BIT_MULTICAST_LATENCY_IRQ])
    else $error("latency flag did not raise the global latency bit");

  port_order_a: assert property ( // RL7
    (status_w[31] == p0_or_w) && (status_w[GIA_BIT_PORT_LO] == p7_or_w))
    else $error("port status bits out of order");

  event_sticky_a: assert property (
    (|rise_w) |=> (st_r.ev_sticky & $past(rise_w)) == $past(rise_w))
    else $error("rising status edge lost from event register");

  mcast_gate_a: assert property ( // RL11
    (status_w == (32'h1 << GIA_BIT_MCAST_EVT)) && !st_r.enable[GIA_BIT_MCAST_EVT] |=> o_int_n)
    else $error("masked multicast event drove the pin");

  // Register port checks
  evmask_write_a: assert property (
    (i_wr && hit_evmask)
    |=> st_r.ev_mask == ($past(i_wdata) & GIA_VALID_MASK))
    else $error("event mask did not take written value");

  evmask_hold_a: assert property (
    !(i_wr && hit_evmask)
    |=> $stable(st_r.ev_mask))
    else $error("event mask changed without a write");

  enable_hold_a: assert property ( // RL11
    !(i_wr && hit_enable)
    |=> $stable(st_r.enable))
    else $error("enable register changed without a write");

  evmask_read_a: assert property (
    (i_rd && hit_evmask)
    |=> o_rdata == $past(st_r.ev_mask))
    else $error("event mask readback wrong");

  event_read_a: assert property (
    (i_rd && hit_event)
    |=> o_rdata == $past(st_r.ev_sticky))
    else $error("event readback wrong");

  rdata_idle_a: assert property (
    !i_rd
    |=> o_rdata == '0)
    else $error("read data not zero outside a read");

  unmapped_read_a: assert property (
    (i_rd && !(hit_status || hit_enable || hit_event || hit_evmask))
    |=> o_rdata == '0)
    else $error("unmapped read returned nonzero data");

  // Event register: read clears, writes are ignored
  event_clear_a: assert property (
    (i_rd && hit_event) && !(|rise_w)
    |=> st_r.ev_sticky == '0)
    else $error("event register not cleared by its read");

  event_keep_a: assert property (
    !(i_rd && hit_event)
    |=> (st_r.ev_sticky & $past(st_r.ev_sticky)) == $past(st_r.ev_sticky))
    else $error("event bit dropped without a read");

  event_nowrite_a: assert property (
    (i_wr && hit_event) && !(|rise_w)
    |=> st_r.ev_sticky == $past(st_r.ev_sticky))
    else $error("write altered the event register");

  event_level_a: assert property (
    o_event_irq == |(st_r.ev_sticky & st_r.ev_mask))
    else $error("event interrupt differs from masked event bits");

  // Layout of the status and enable words
  status_rsvd_a: assert property ( // RL8
    (status_w & ~GIA_VALID_MASK) == '0)
    else $error("reserved status bit set");

  enable_rsvd_a: assert property ( // RL12
    (st_r.enable & ~GIA_VALID_MASK) == '0)
    else $error("reserved enable bit set");

  fabric_src_a: assert property ( // RL5
    status_w[GIA_BIT_FABRIC_ERR] == |i_fabric_err)
    else $error("fabric error bit differs from OR of its flags");

  latency_src_a: assert property ( // RL6
    status_w[GIA_BIT_MULTICAST_LATENCY_IRQ] == |i_mc_latency_err)
    else $error("latency bit differs from OR of its flags");

  // A lone source with its enable bit clear must leave the pin released; an enabled I2C request must pull it low
  i2c_gate_a: assert property ( // RL4
    (status_w == (32'h1 << GIA_BIT_I2C)) && !st_r.enable[GIA_BIT_I2C]
    |=> o_int_n)
    else $error("masked I2C request drove the pin");

  fabric_gate_a: assert property ( // RL5
    (status_w == (32'h1 << GIA_BIT_FABRIC_ERR)) && !st_r.enable[GIA_BIT_FABRIC_ERR]
    |=> o_int_n)
    else $error("masked fabric error drove the pin");

  reset_gate_a: assert property ( // RL10
    (status_w == (32'h1 << GIA_BIT_RESET_SYM)) && !st_r.enable[GIA_BIT_RESET_SYM]
    |=> o_int_n)
    else $error("masked reset-symbol request drove the pin");

  latency_gate_a: assert property ( // RL12
    (status_w == (32'h1 << GIA_BIT_MULTICAST_LATENCY_IRQ)) && !st_r.enable[GIA_BIT_MULTICAST_LATENCY_IRQ]
    |=> o_int_n)
    else $error("masked latency request drove the pin");

  i2c_pass_a: assert property ( // RL4
    status_w[GIA_BIT_I2C] && st_r.enable[GIA_BIT_I2C]
    |=> !o_int_n)
    else $error("enabled I2C request did not drive the pin");

  // Each port reaches the pin through its own enable bit
  for (genvar p = 0; p < GIA_NUM_PORTS; p++) begin : g_port_chk
    localparam int PORT_BIT = GIA_BIT_PORT_LO + GIA_NUM_PORTS - 1 - p;
    port_pass_a: assert property ( // RL7
      (|i_port_req[p*PORT_REQS +: PORT_REQS]) && st_r.enable[PORT_BIT]
      |=> !o_int_n)
      else $error("enabled port request did not drive the pin");
  end

  pin_cycle_c: cover property (o_int_n ##1 !o_int_n ##[1:20] o_int_n);
  status_rd_c: cover property (!o_int_n && i_rd && hit_status);
  en_wr_c:     cover property (i_wr && hit_enable ##1 !o_int_n);
  ev_clear_c:  cover property (o_event_irq ##0 (i_rd && hit_event) ##1 !o_event_irq);
  port_pin_c:  cover property ((|status_w[31:24]) && !o_int_n);

endmodule : gia_global_irq

`default_nettype wire

// ===== sim/gia_host_model.sv
// Host processor interrupt input watching the active-low interrupt pin.
// Assumes the pin is sampled on the core clock, as a synchronised host input would be.
`timescale 1ns/100ps
`default_nettype none
module gia_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_int_n,
  output var  logic o_irq_seen
);
  // Sticky so a short assertion is never missed by the bench
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq_seen <= 1'b0;
    end else if (!i_int_n) begin
      o_irq_seen <= 1'b1;
    end
  end
endmodule : gia_host_model
`default_nettype wire

// ===== sim/global_interrupt_aggregator_test.sv
// Self-checking bench: register port, live status, pin gating and event interrupt.
// Assumes gia_pkg and gia_global_irq with default parameters (two requests per port).
`timescale 1ns/100ps
`default_nettype none
module test_global_interrupt_aggregator;
  import gia_pkg::*;
  logic        clk, arst_n, wr, rd, int_n, ev_irq, seen, i2c, rd_q;
  logic [16:0] addr;
  logic [31:0] wdata, rdata, en;
  logic [15:0] preq;
  logic [7:0]  rs, mc, fe, lat;
  logic [31:0] exp_q[$];
  int          num_errors, check_count;
  gia_global_irq dut_u (.i_core_clk(clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_port_req(preq), .i_reset_symbol_req(rs), .i_multicast_event_req(mc),
    .i_i2c_req(i2c), .i_fabric_err(fe), .i_mc_latency_err(lat), .o_int_n(int_n), .o_event_irq(ev_irq));
  gia_host_model host_u (.i_core_clk(clk), .i_arst_n(arst_n), .i_int_n(int_n), .o_irq_seen(seen));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] live();
    logic [31:0] s;
    s = {17'h0, |lat, 6'h0, |fe, i2c, |mc, |rs, 4'h0};
    for (int p = 0; p < 8; p++) s[31-p] = |preq[p*2 +: 2];
    return s;
  endfunction : live
  task automatic finish_test();
    $display("errors %0d, checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic wr_reg(input logic [16:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [16:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // Registered outputs lag one edge; the extra edge keeps sampling clear of it
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  always @(posedge clk) begin
    if (rd_q) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("wrong value at %0t: read data with nothing expected", $time);
      end else begin
        chk_word(rdata, exp_q.pop_front());
      end
    end
    rd_q <= rd;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    finish_test();
  end
  initial begin
    arst_n      = 1'b0;
    wr          = 1'b0;
    rd          = 1'b0;
    addr        = '0;
    wdata       = '0;
    en          = '0;
    preq        = '0;
    rs          = '0;
    mc          = '0;
    fe          = '0;
    lat         = '0;
    i2c         = 1'b0;
    num_errors  = 0;
    check_count = 0;
    void'($urandom(32'hDE4E));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    chk_bit(int_n, 1'b1);
    rd_reg(GIA_STATUS_OFS, 32'h00000000);
    rd_reg(GIA_ENABLE_OFS, 32'h00000000);
    wr_reg(GIA_EVMASK_OFS, 32'h00000040);
    rd_reg(GIA_EVMASK_OFS, 32'h00000040);
    @(posedge clk);
    i2c <= 1'b1;
    settle();
    chk_bit(ev_irq, 1'b1);
    chk_bit(int_n, 1'b1);
    rd_reg(GIA_EVENT_OFS, 32'h00000040);
    settle();
    chk_bit(ev_irq, 1'b0);
    wr_reg(GIA_ENABLE_OFS, 32'hFFFFFFFF);
    rd_reg(GIA_ENABLE_OFS, 32'hFF0040F0);
    settle();
    chk_bit(int_n, 1'b0);
    wr_reg(GIA_STATUS_OFS, 32'h00000000);
    rd_reg(GIA_STATUS_OFS, 32'h00000040);
    rd_reg(17'h1AC10, 32'h00000000);
    @(posedge clk);
    i2c <= 1'b0;
    fe  <= 8'h08;
    settle();
    chk_bit(int_n, 1'b0);
    @(posedge clk);
    fe <= 8'h00;
    settle();
    chk_bit(int_n, 1'b1);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      preq <= 16'($urandom & $urandom);
      rs   <= 8'($urandom & $urandom & $urandom);
      mc   <= 8'($urandom & $urandom & $urandom);
      fe   <= 8'($urandom & $urandom & $urandom);
      lat  <= 8'($urandom & $urandom & $urandom);
      i2c  <= 1'($urandom);
      en = $urandom;
      wr_reg(GIA_ENABLE_OFS, en);
      rd_reg(GIA_STATUS_OFS, live());
      settle();
      chk_bit(int_n, ~|(live() & en & GIA_VALID_MASK));
    end
    repeat (3) @(posedge clk);
    chk_bit(seen, 1'b1);
    // Mid-run reset with sources still active: enables return to zero, pin stays released
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    chk_bit(int_n, 1'b1);
    rd_reg(GIA_ENABLE_OFS, 32'h00000000);
    settle();
    chk_bit(int_n, 1'b1);
    chk_bit(seen, 1'b0);
    finish_test();
  end
endmodule : test_global_interrupt_aggregator
`default_nettype wire
